// *** design/cftc_csrs.sv ***
// Float, hardware-loop and trap CSR bank of a 32-bit core.
// Assumes CSR requests, trap events and loop updates come from logic on clk;
// irq_lines come from pins and are synchronised here.
`timescale 1ns/100ps
`include "cftc_consts.svh"

// Operation
// - Rounding-mode register exists with FPU; bits 2:0 writable, upper bits zero.
// - Float control/status exists with FPU; bits 7:5 mode, 4:0 flags.
// - Float control/status bits 31:8 ignore writes and read zero.
// - Flags bit 4 to 0: invalid, divide-zero, overflow, underflow, inexact.
// - Two read-only loop begin-address registers with custom extension, reset zero.
// - Two read-only loop end-address registers with custom extension, reset zero.
// - Two read-only loop iteration-count registers with custom extension, reset zero.
// - Status bits 14:13 float state, zero without FPU or float-in-int mode.
// - Status bit 31 reads one exactly when float state is dirty.
// - Previous privilege bits 12:11 read-only eleven without user mode.
// - Trap entry copies global interrupt enable into previous enable bit 7.
// - Return from trap restores global enable from previous enable.
// - Status bit 3 is software-writable global interrupt enable.
// - Status bits 30:15, 10:8, 6:4, 2:0 read zero.
// - Enable bits 31:16 enable fast interrupt lines of same index.
// - Enable bit 11 enables external interrupt line 11.
// - Enable bit 7 enables timer interrupt line 7.
// - Enable bit 3 enables software interrupt line 3.
// - Other enable bits read zero; enable register resets to zero.
// - Trap base writable in bits 31:8; bits 7:2 read zero.
// - Trap vector bit 1 zero; bit 0 selects direct or vectored.
// - Trap vector starts as boot address 31:8, zeros, then 01.
// - Traps branch to handler using trap base bits 31:8.
module cftc_csrs #(
  parameter bit FPU = 1'b1,
  parameter bit FLOAT_IN_INT_REGS = 1'b0,
  parameter bit CUSTOM_EXT_ENABLE = 1'b1,
  parameter bit USER_MODE_ENABLE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // CSR access
  input wire cftc_pkg::cftc_req_type csr_req,
  output logic csr_ack,
  output logic [31:0] csr_rdata,
  output logic csr_illegal,
  // Boot
  input wire logic [31:0] trap_vector_boot_input,
  // Float unit
  input wire logic fpu_flags_valid,
  input wire logic [4:0] fpu_flags,
  input wire logic fpu_dirty,
  output logic [2:0] round_mode_out,
  // Hardware loop controller
  input wire cftc_pkg::cftc_loop_wr_type loop_wr,
  // Trap sequencing
  input wire cftc_pkg::cftc_trap_type trap_evt,
  output logic trap_jump,
  output logic [31:0] trap_target,
  // Interrupts
  input wire logic [31:0] irq_lines,
  output logic [31:0] irq_enabled_pending,
  output logic irq_request,
  output logic global_irq_enable_out
);

  // Stored state
  logic [2:0] round_mode;
  logic [4:0] fp_flags;
  logic [1:0] fp_state;
  logic [1:0] prev_priv;
  logic prev_irq_enable;
  logic global_irq_enable;
  logic [31:0] irq_enable;
  logic [23:0] tvec_base;
  logic tvec_mode;
  logic boot_pending;
  logic [31:0] loop_mem [0:1][0:2];

  // Pin synchroniser and filtered level
  logic [31:0] irq_s1;
  logic [31:0] irq_s2;
  logic [31:0] irq_s3;
  logic [31:0] irq_stable;
  logic [31:0] irq_agree;

  // Access decode
  logic fp_on;
  logic state_dirty_flag;
  logic read_hit;
  logic [31:0] read_value;
  logic read_only_addr;
  logic wr_en;
  logic [31:0] new_value;
  logic wr_flags;
  logic wr_round;
  logic wr_ctrl;
  logic wr_status;
  logic wr_irq_en;
  logic wr_tvec;
  logic [1:0] next_fp_state;
  logic [4:0] next_fp_flags;

  // Value a CSR instruction leaves in the register
  function automatic logic [31:0] cftc_apply(
    input cftc_pkg::cftc_op_type op,
    input logic [31:0] old,
    input logic [31:0] wdata
  );
    logic [31:0] result;
    result = old;
    case (op)
      cftc_pkg::op_write: result = wdata;
      cftc_pkg::op_set: result = old | wdata;
      cftc_pkg::op_clear: result = old & ~wdata;
      default: result = old;
    endcase
    return result;
  endfunction

  // Handler address for a trap
  function automatic logic [31:0] cftc_target(
    input logic [23:0] base,
    input logic mode,
    input logic is_irq,
    input logic [4:0] cause
  );
    logic [31:0] result;
    result = {base, 8'h00};
    if (mode && is_irq) begin
      result = {base, 8'h00} + {25'h0000000, cause, 2'h0};
    end
    return result;
  endfunction

  // Float state is forced off when there is no separate float file
  assign fp_on = FPU && !FLOAT_IN_INT_REGS;
  assign state_dirty_flag = fp_on && (fp_state == `CFTC_FP_STATE_DIRTY);

  // Read view of every register
  always_comb begin
    read_hit = 1'b1;
    read_value = 32'h00000000;
    if (FPU && csr_req.addr == `CFTC_ADDR_FLOAT_FLAGS) begin
      read_value = {27'h0000000, fp_flags};
    end else if (FPU && csr_req.addr == `CFTC_ADDR_FLOAT_ROUND_MODE) begin
      read_value = {29'h00000000, round_mode};
    end else if (FPU && csr_req.addr == `CFTC_ADDR_FLOAT_CTRL_STATUS) begin
      read_value = {24'h000000, round_mode, fp_flags};
    end else if (csr_req.addr == `CFTC_ADDR_MACHINE_STATUS) begin
      read_value[`CFTC_STATUS_DIRTY_BIT] = state_dirty_flag;
      read_value[`CFTC_STATUS_FP_STATE_LO +: 2] = fp_state;
      read_value[`CFTC_STATUS_PRIV_LO +: 2] = prev_priv;
      read_value[`CFTC_STATUS_PREV_IE_BIT] = prev_irq_enable;
      read_value[`CFTC_STATUS_GLOBAL_IE_BIT] = global_irq_enable;
    end else if (csr_req.addr == `CFTC_ADDR_MACHINE_IRQ_ENABLE) begin
      read_value = irq_enable;
    end else if (csr_req.addr == `CFTC_ADDR_TRAP_VECTOR_BASE) begin
      read_value = {tvec_base, 6'h00, 1'b0, tvec_mode};
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP0_BEGIN) begin
      read_value = loop_mem[0][0];
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP0_FINISH) begin
      read_value = loop_mem[0][1];
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP0_ITER) begin
      read_value = loop_mem[0][2];
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP1_BEGIN) begin
      read_value = loop_mem[1][0];
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP1_FINISH) begin
      read_value = loop_mem[1][1];
    end else if (CUSTOM_EXT_ENABLE && csr_req.addr == `CFTC_ADDR_LOOP1_ITER) begin
      read_value = loop_mem[1][2];
    end else begin
      read_hit = 1'b0;
    end
  end

  // Top two address bits 11 mark a read-only CSR
  assign read_only_addr = (csr_req.addr[11:10] == 2'h3);
  assign wr_en = csr_req.valid && read_hit && !read_only_addr && (csr_req.op != cftc_pkg::op_read);
  assign new_value = cftc_apply(csr_req.op, read_value, csr_req.wdata);
  assign wr_flags = wr_en && (csr_req.addr == `CFTC_ADDR_FLOAT_FLAGS);
  assign wr_round = wr_en && (csr_req.addr == `CFTC_ADDR_FLOAT_ROUND_MODE);
  assign wr_ctrl = wr_en && (csr_req.addr == `CFTC_ADDR_FLOAT_CTRL_STATUS);
  assign wr_status = wr_en && (csr_req.addr == `CFTC_ADDR_MACHINE_STATUS);
  assign wr_irq_en = wr_en && (csr_req.addr == `CFTC_ADDR_MACHINE_IRQ_ENABLE);
  assign wr_tvec = wr_en && (csr_req.addr == `CFTC_ADDR_TRAP_VECTOR_BASE);

  // Access answer, one cycle after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csr_ack <= 1'b0;
      csr_rdata <= `CFTC_ZERO_RESET;
      csr_illegal <= 1'b0;
    end else begin
      csr_ack <= csr_req.valid;
      csr_rdata <= (csr_req.valid && read_hit) ? read_value : 32'h00000000;
      csr_illegal <= csr_req.valid && (!read_hit || (read_only_addr && csr_req.op != cftc_pkg::op_read));
    end
  end

  // Rounding mode, one store behind both float views
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      round_mode <= 3'h0;
    end else if (!FPU) begin
      round_mode <= 3'h0;
    end else if (wr_round) begin
      round_mode <= new_value[2:0];
    end else if (wr_ctrl) begin
      round_mode <= new_value[`CFTC_CTRL_ROUND_LO +: 3];
    end
  end

  assign round_mode_out = round_mode;

  // Accrued flags; unit reports are ORed after the write so none is lost
  always_comb begin
    next_fp_flags = fp_flags;
    if (wr_flags || wr_ctrl) begin
      next_fp_flags = new_value[4:0];
    end
    if (fpu_flags_valid) begin
      next_fp_flags = next_fp_flags | fpu_flags;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fp_flags <= 5'h00;
    end else begin
      fp_flags <= FPU ? next_fp_flags : 5'h00;
    end
  end

  // Float state; unit reports and float CSR writes mark it dirty, a status write sets it as written
  always_comb begin
    next_fp_state = fp_state;
    if (wr_status) begin
      next_fp_state = new_value[`CFTC_STATUS_FP_STATE_LO +: 2];
    end
    if (fpu_dirty || fpu_flags_valid || wr_flags || wr_round || wr_ctrl) begin
      next_fp_state = `CFTC_FP_STATE_DIRTY;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fp_state <= 2'h0;
    end else begin
      fp_state <= fp_on ? next_fp_state : 2'h0;
    end
  end

  // Previous privilege; only machine and user are legal when user mode exists
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_priv <= `CFTC_PRIV_MACHINE;
    end else if (!USER_MODE_ENABLE) begin
      prev_priv <= `CFTC_PRIV_MACHINE;
    end else if (wr_status && (new_value[`CFTC_STATUS_PRIV_LO +: 2] == `CFTC_PRIV_USER
                               || new_value[`CFTC_STATUS_PRIV_LO +: 2] == `CFTC_PRIV_MACHINE)) begin
      prev_priv <= new_value[`CFTC_STATUS_PRIV_LO +: 2];
    end
  end

  // Interrupt-enable stacking; trap entry outranks a CSR write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (trap_evt.enter) begin
      prev_irq_enable <= global_irq_enable;
      global_irq_enable <= 1'b0;
    end else if (trap_evt.mret) begin
      global_irq_enable <= prev_irq_enable;
      prev_irq_enable <= 1'b1;
    end else if (wr_status) begin
      global_irq_enable <= new_value[`CFTC_STATUS_GLOBAL_IE_BIT];
    end
  end

  assign global_irq_enable_out = global_irq_enable;

  // Interrupt enables; unused bits never store a one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable <= `CFTC_ZERO_RESET;
    end else if (wr_irq_en) begin
      irq_enable <= new_value & `CFTC_IRQ_EN_MASK;
    end
  end

  // Trap vector; the boot address is a port, so it is taken after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tvec_base <= 24'h000000;
      tvec_mode <= `CFTC_TVEC_MODE_RESET;
      boot_pending <= 1'b1;
    end else if (boot_pending) begin
      tvec_base <= trap_vector_boot_input[31:`CFTC_TVEC_BASE_LO];
      tvec_mode <= `CFTC_TVEC_MODE_RESET;
      boot_pending <= 1'b0;
    end else if (wr_tvec) begin
      tvec_base <= new_value[31:`CFTC_TVEC_BASE_LO];
      tvec_mode <= new_value[0];
    end
  end

  // Handler jump, one cycle after the trap event
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trap_jump <= 1'b0;
      trap_target <= `CFTC_ZERO_RESET;
    end else begin
      trap_jump <= trap_evt.enter;
      if (trap_evt.enter) begin
        trap_target <= cftc_target(tvec_base, tvec_mode, trap_evt.is_irq, trap_evt.cause);
      end
    end
  end

  // Loop registers; only the loop controller writes them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        for (int j = 0; j < 3; j++) begin
          loop_mem[i][j] <= `CFTC_ZERO_RESET;
        end
      end
    end else if (CUSTOM_EXT_ENABLE && loop_wr.valid && loop_wr.field != 2'h3) begin
      loop_mem[loop_wr.idx][loop_wr.field] <= loop_wr.value;
    end
  end

  // Interrupt pins: three flops, a change counts once stages two and three agree
  assign irq_agree = ~(irq_s2 ^ irq_s3);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_s1 <= 32'h00000000;
      irq_s2 <= 32'h00000000;
      irq_s3 <= 32'h00000000;
      irq_stable <= 32'h00000000;
    end else begin
      irq_s1 <= irq_lines;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      irq_stable <= (irq_s3 & irq_agree) | (irq_stable & ~irq_agree);
    end
  end

  // Enabled pending lines and the request to the sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enabled_pending <= 32'h00000000;
      irq_request <= 1'b0;
    end else begin
      irq_enabled_pending <= irq_stable & irq_enable;
      irq_request <= global_irq_enable && (|(irq_stable & irq_enable));
    end
  end

endmodule // cftc_csrs

// *** inc/cftc_consts.svh ***
// Offsets, field positions and reset values of the float, loop and trap CSR bank.
// Assumes a 12-bit CSR address and 32-bit CSR data.
`ifndef CFTC_CONSTS_SVH
`define CFTC_CONSTS_SVH

// CSR addresses
`define CFTC_ADDR_FLOAT_FLAGS 12'h001
`define CFTC_ADDR_FLOAT_ROUND_MODE 12'h002
`define CFTC_ADDR_FLOAT_CTRL_STATUS 12'h003
`define CFTC_ADDR_MACHINE_STATUS 12'h300
`define CFTC_ADDR_MACHINE_IRQ_ENABLE 12'h304
`define CFTC_ADDR_TRAP_VECTOR_BASE 12'h305
`define CFTC_ADDR_LOOP0_BEGIN 12'hCC0
`define CFTC_ADDR_LOOP0_FINISH 12'hCC1
`define CFTC_ADDR_LOOP0_ITER 12'hCC2
`define CFTC_ADDR_LOOP1_BEGIN 12'hCC4
`define CFTC_ADDR_LOOP1_FINISH 12'hCC5
`define CFTC_ADDR_LOOP1_ITER 12'hCC6

// Field positions
`define CFTC_CTRL_ROUND_LO 5
`define CFTC_STATUS_DIRTY_BIT 31
`define CFTC_STATUS_FP_STATE_LO 13
`define CFTC_STATUS_PRIV_LO 11
`define CFTC_STATUS_PREV_IE_BIT 7
`define CFTC_STATUS_GLOBAL_IE_BIT 3
`define CFTC_TVEC_BASE_LO 8

// Masks, codes and reset values
`define CFTC_IRQ_EN_MASK 32'hFFFF0888
`define CFTC_FP_STATE_DIRTY 2'h3
`define CFTC_PRIV_MACHINE 2'h3
`define CFTC_PRIV_USER 2'h0
`define CFTC_TVEC_MODE_RESET 1'h1
`define CFTC_MACHINE_STATUS_RESET 32'h00001800
`define CFTC_ZERO_RESET 32'h00000000

`endif

// *** inc/cftc_pkg.sv ***
// Types shared by the float, loop and trap CSR bank.
// Assumes the constants header is available on the include path.
package cftc_pkg;

  typedef enum logic [1:0] {
    op_read = 2'h0,
    op_write = 2'h1,
    op_set = 2'h2,
    op_clear = 2'h3
  } cftc_op_type;

  typedef struct packed {
    logic valid;
    cftc_op_type op;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cftc_req_type;

  typedef struct packed {
    logic enter;
    logic is_irq;
    logic [4:0] cause;
    logic mret;
  } cftc_trap_type;

  typedef enum logic [1:0] {
    loop_field_begin,
    loop_field_finish,
    loop_field_count
  } cftc_loop_field_type;

  typedef struct packed {
    logic valid;
    logic idx;
    cftc_loop_field_type field;
    logic [31:0] value;
  } cftc_loop_wr_type;

endpackage

// *** dv/cftc_csrs_asserts.sv ***
// Concurrent checks on the ports of the float, loop and trap CSR bank.
// Assumes one clock domain, clk, and the design's asynchronous active-low rstn.
`timescale 1ns/100ps
module cftc_csrs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // CSR access
  input wire cftc_pkg::cftc_req_type csr_req,
  input wire logic csr_ack,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_illegal,
  // Trap and interrupt
  input wire cftc_pkg::cftc_trap_type trap_evt,
  input wire logic trap_jump,
  input wire logic [31:0] irq_enabled_pending,
  input wire logic global_irq_enable_out,
  input wire logic [2:0] round_mode_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_round_mode_write: assert property (
    csr_req.valid && csr_req.op == cftc_pkg::op_write && csr_req.addr == 12'h002
    |=> round_mode_out == $past(csr_req.wdata[2:0])) else $error("rounding mode not written");
  a_ctrl_mode_view: assert property (
    csr_req.valid && csr_req.op == cftc_pkg::op_write && csr_req.addr == 12'h003
    |=> round_mode_out == $past(csr_req.wdata[7:5])) else $error("control view mode not shared");
  a_ctrl_upper_zero: assert property (
    csr_ack && $past(csr_req.addr) == 12'h003 |-> csr_rdata[31:8] == 24'h0) else $error("control upper bits set");
  a_loop_write_refused: assert property (
    csr_req.valid && csr_req.op != cftc_pkg::op_read && csr_req.addr[11:4] == 8'hCC
    |=> csr_ack && csr_illegal) else $error("loop register write accepted");
  a_status_fixed_bits: assert property (
    csr_ack && $past(csr_req.addr) == 12'h300
    |-> (csr_rdata & 32'h7FFF8777) == 32'h0 && csr_rdata[12:11] == 2'h3) else $error("status fixed bits wrong");
  a_status_dirty_flag: assert property (
    csr_ack && $past(csr_req.addr) == 12'h300
    |-> csr_rdata[31] == (csr_rdata[14:13] == 2'h3)) else $error("dirty flag disagrees with float state");
  a_pending_masked: assert property (
    (irq_enabled_pending & 32'h0000F777) == 32'h0) else $error("pending on a line without enable");
  a_entry_jumps: assert property (
    trap_evt.enter |=> trap_jump && !global_irq_enable_out) else $error("trap entry without jump");
  a_tvec_fixed_bits: assert property (
    csr_ack && $past(csr_req.addr) == 12'h305 |-> csr_rdata[7:1] == 7'h0) else $error("trap vector low bits set");
endmodule // cftc_csrs_asserts

bind cftc_csrs cftc_csrs_asserts cftc_csrs_asserts_inst (.clk(clk), .rstn(rstn), .csr_req(csr_req),
  .csr_ack(csr_ack), .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .trap_evt(trap_evt),
  .trap_jump(trap_jump), .irq_enabled_pending(irq_enabled_pending),
  .global_irq_enable_out(global_irq_enable_out), .round_mode_out(round_mode_out));

// *** dv/cftc_csrs_test.sv ***
// Self-checking bench for the float, loop and trap CSR bank.
// Assumes the package is compiled first; default parameters of the design.
`timescale 1ns/100ps
module cftc_csrs_test;
  typedef struct packed {
    logic [1:0] op;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ill;
  } cftc_row_type;
  logic clk, rstn, csr_ack, csr_illegal, trap_jump, irq_request, global_irq_enable_out, fpu_flags_valid, fpu_dirty;
  logic [31:0] csr_rdata, trap_target, irq_enabled_pending, irq_lines, boot;
  logic [4:0] fpu_flags;
  logic [2:0] round_mode_out;
  cftc_pkg::cftc_req_type csr_req;
  cftc_pkg::cftc_trap_type trap_evt;
  cftc_pkg::cftc_loop_wr_type loop_wr;
  int n_errors, n_compared;
  int lines [6] = '{3, 7, 11, 16, 31, 5};
  // Old value comes back on every access, so each row checks the reset value or the previous write
  cftc_row_type rows [31] = '{
    '{2'h0, 12'h300, 32'h0, 32'h00001800, 1'h0}, '{2'h0, 12'h304, 32'h0, 32'h0, 1'h0},
    '{2'h0, 12'h305, 32'h0, 32'h12345601, 1'h0}, '{2'h0, 12'h002, 32'h0, 32'h0, 1'h0},
    '{2'h0, 12'h003, 32'h0, 32'h0, 1'h0}, '{2'h0, 12'hCC0, 32'h0, 32'h0, 1'h0},
    '{2'h0, 12'hCC1, 32'h0, 32'h0, 1'h0}, '{2'h0, 12'hCC2, 32'h0, 32'h0, 1'h0},
    '{2'h1, 12'hCC0, 32'hFFFFFFFF, 32'h0, 1'h1}, '{2'h1, 12'h304, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{2'h0, 12'h304, 32'h0, 32'hFFFF0888, 1'h0}, '{2'h1, 12'h305, 32'hFFFFFFFF, 32'h12345601, 1'h0},
    '{2'h0, 12'h305, 32'h0, 32'hFFFFFF01, 1'h0}, '{2'h1, 12'h002, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{2'h0, 12'h003, 32'h0, 32'h000000E0, 1'h0}, '{2'h1, 12'h003, 32'hFFFFFFFF, 32'h000000E0, 1'h0},
    '{2'h0, 12'h003, 32'h0, 32'h000000FF, 1'h0}, '{2'h0, 12'h001, 32'h0, 32'h0000001F, 1'h0},
    '{2'h3, 12'h001, 32'h0000000A, 32'h0000001F, 1'h0}, '{2'h0, 12'h003, 32'h0, 32'h000000F5, 1'h0},
    '{2'h0, 12'h002, 32'h0, 32'h00000007, 1'h0}, '{2'h0, 12'h300, 32'h0, 32'h80007800, 1'h0},
    '{2'h1, 12'h300, 32'h00002008, 32'h80007800, 1'h0}, '{2'h0, 12'h300, 32'h0, 32'h00003808, 1'h0},
    '{2'h1, 12'h300, 32'hFFFFFFFF, 32'h00003808, 1'h0}, '{2'h0, 12'h300, 32'h0, 32'h80007808, 1'h0},
    '{2'h0, 12'h123, 32'h0, 32'h0, 1'h1}, '{2'h1, 12'h305, 32'h0000AB01, 32'hFFFFFF01, 1'h0},
    '{2'h0, 12'h305, 32'h0, 32'h0000AB01, 1'h0}, '{2'h2, 12'h001, 32'h0000000A, 32'h00000015, 1'h0},
    '{2'h0, 12'h003, 32'h0, 32'h000000FF, 1'h0}};

  cftc_csrs cftc_csrs_inst (.clk(clk), .rstn(rstn), .csr_req(csr_req), .csr_ack(csr_ack), .csr_rdata(csr_rdata),
    .csr_illegal(csr_illegal), .trap_vector_boot_input(boot), .fpu_flags_valid(fpu_flags_valid),
    .fpu_flags(fpu_flags), .fpu_dirty(fpu_dirty), .round_mode_out(round_mode_out), .loop_wr(loop_wr),
    .trap_evt(trap_evt), .trap_jump(trap_jump), .trap_target(trap_target), .irq_lines(irq_lines),
    .irq_enabled_pending(irq_enabled_pending), .irq_request(irq_request),
    .global_irq_enable_out(global_irq_enable_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Answer stands for one cycle only, so it is looked at right after the taking edge
  task acc(input logic [1:0] op, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] er, input logic ei);
    @(posedge clk);
    #1;
    csr_req = {1'h1, cftc_pkg::cftc_op_type'(op), a, wd};
    @(posedge clk);
    #1;
    csr_req = '0;
    chk("ack", 32'h1, {31'h0, csr_ack});
    chk("rdata", er, csr_rdata);
    chk("illegal", {31'h0, ei}, {31'h0, csr_illegal});
  endtask

  task trap(input logic irq, input logic [4:0] c, input logic m);
    @(posedge clk);
    #1;
    trap_evt = {~m, irq, c, m};
    @(posedge clk);
    #1;
    trap_evt = '0;
  endtask

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    csr_req = '0;
    trap_evt = '0;
    loop_wr = '0;
    irq_lines = 32'h0;
    boot = 32'h12345678;
    fpu_flags_valid = 1'b0;
    fpu_flags = 5'h0;
    fpu_dirty = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].op, rows[i].addr, rows[i].wdata, rows[i].rdata, rows[i].ill);
    end
    $display("test rows done");
    trap(1'b1, 5'h0B, 1'b0);
    chk("jump", 32'h1, {31'h0, trap_jump});
    chk("target", 32'h0000AB2C, trap_target);
    acc(2'h0, 12'h300, 32'h0, 32'h80007880, 1'h0);
    trap(1'b0, 5'h02, 1'b0);
    chk("target", 32'h0000AB00, trap_target);
    acc(2'h0, 12'h300, 32'h0, 32'h80007800, 1'h0);
    trap(1'b0, 5'h0, 1'b1);
    acc(2'h0, 12'h300, 32'h0, 32'h80007880, 1'h0);
    trap(1'b0, 5'h0, 1'b1);
    acc(2'h0, 12'h300, 32'h0, 32'h80007888, 1'h0);
    $display("test trap done");
    foreach (lines[k]) begin
      irq_lines = 32'h1 << lines[k];
      repeat (6) @(posedge clk);
      #1;
      chk("pending", (32'h1 << lines[k]) & 32'hFFFF0888, irq_enabled_pending);
      chk("request", {31'h0, lines[k] != 5}, {31'h0, irq_request});
    end
    irq_lines = 32'h00000080;
    trap(1'b1, 5'h07, 1'b0);
    chk("target", 32'h0000AB1C, trap_target);
    repeat (6) @(posedge clk);
    #1;
    chk("request", 32'h0, {31'h0, irq_request});
    $display("test irq done");
    for (int i = 0; i < 2; i++) begin
      for (int f = 0; f < 3; f++) begin
        @(posedge clk);
        #1;
        loop_wr = {1'h1, i[0], 2'(f), 32'hA0000000 | 32'(i * 16 + f)};
        @(posedge clk);
        #1;
        loop_wr = '0;
        acc(2'h0, 12'hCC0 + 12'(i * 4 + f), 32'h0, 32'hA0000000 | 32'(i * 16 + f), 1'h0);
      end
    end
    // Field code 3 names no register and must leave the store alone
    loop_wr = {1'h1, 1'h0, 2'h3, 32'h55555555};
    @(posedge clk);
    #1;
    loop_wr = '0;
    acc(2'h0, 12'hCC0, 32'h0, 32'hA0000000, 1'h0);
    $display("test loop done");
    // Mid-run reset must bring status, enables, trap vector and loop count back, boot vector included
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    acc(2'h0, 12'h300, 32'h0, 32'h00001800, 1'h0);
    acc(2'h0, 12'h304, 32'h0, 32'h0, 1'h0);
    acc(2'h0, 12'h305, 32'h0, 32'h12345601, 1'h0);
    acc(2'h0, 12'hCC6, 32'h0, 32'h0, 1'h0);
    fpu_flags_valid = 1'b1;
    fpu_flags = 5'h11;
    @(posedge clk);
    #1;
    fpu_flags_valid = 1'b0;
    acc(2'h0, 12'h001, 32'h0, 32'h00000011, 1'h0);
    acc(2'h0, 12'h300, 32'h0, 32'h80007800, 1'h0);
    acc(2'h1, 12'h300, 32'h00002000, 32'h80007800, 1'h0);
    acc(2'h0, 12'h300, 32'h0, 32'h00003800, 1'h0);
    fpu_dirty = 1'b1;
    @(posedge clk);
    #1;
    fpu_dirty = 1'b0;
    acc(2'h0, 12'h300, 32'h0, 32'h80007800, 1'h0);
    $display("test reset done");
    complete_run();
  end
endmodule // cftc_csrs_test
